/* pkg/rpc_pkg.sv */
// Package for the reset and power reduction controller: register map, fields, timings, carriers
package rpc_pkg;

  // Wishbone register map (byte addresses)
  localparam logic [7:0] ADDR_MODULE_POWER_GATES = 8'h64; // Module clock gate register
  localparam logic [7:0] ADDR_RESET_CONFIG       = 8'h68; // Start-up and clock source fuse copy
  localparam logic [7:0] ADDR_RESET_STATUS       = 8'h6c; // Live reset and reference state

  // Module power gate fields
  localparam int BIT_GATE_TWO_WIRE      = 7;
  localparam int BIT_GATE_TIMER_ASYNC8  = 6;
  localparam int BIT_GATE_TIMER_FIRST8  = 5;
  localparam int BIT_GATE_SERIAL_PORT_B = 4;
  localparam int BIT_GATE_TIMER_WIDE16  = 3;
  localparam int BIT_GATE_SYNC_SERIAL   = 2;
  localparam int BIT_GATE_SERIAL_PORT_A = 1;
  localparam int BIT_GATE_CONVERTER     = 0;
  localparam logic [7:0] GATES_RESET    = 8'h00;

  // Reset config fields: [5:4] start-up time fuses, [3:0] clock source fuses
  localparam int CFG_SUT_LSB = 4;
  localparam int CFG_CLOCK_SOURCE_FUSES_LSB = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // Status fields
  localparam int ST_INT_RESET  = 0;
  localparam int ST_PORT_RESET = 1;
  localparam int ST_BANDGAP    = 2;
  localparam int ST_COUNTING   = 3;

  // Timing at 40 MHz
  localparam int CLK_PERIOD_PS      = 25000;
  localparam int STARTUP_SHORT_US   = 4;    // Fast start-up delay period
  localparam int BROWNOUT_MIN_NS    = 2000; // Least brown-out duration before a flag
  localparam int STARTUP_SHORT_CYC  = (STARTUP_SHORT_US * 1000000) / CLK_PERIOD_PS;
  localparam int BROWNOUT_MIN_CYC   = (BROWNOUT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int EXT_MIN_PULSE_NS   = 2500; // Least external reset pulse width
  localparam int EXT_MIN_PULSE_CYC  = (EXT_MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STARTUP_LONG_CYC   = 65536 * 4; // Slow start-up default, a parameter in the top

  // Delay counter states, Gray coded along the path
  typedef enum logic [1:0] {
    RPC_ST_HOLD  = 2'b00,
    RPC_ST_COUNT = 2'b01,
    RPC_ST_RUN   = 2'b11
  } rpc_state_t;

  // Raw reset sources from detectors and core
  typedef struct packed {
    logic power_low;     // Power-on detector, high below threshold
    logic ext_reset_n;   // External reset pin, low active
    logic wdog_expired;  // Watchdog period expired
    logic wdog_enabled;  // Watchdog in reset mode
    logic supply_low;    // Brown-out comparator raw output
    logic test_reset;    // Test-port reset register bit
  } rpc_sources_t;

  // Peripheral requests that steer the bandgap and gates
  typedef struct packed {
    logic [2:0] brownout_level_fuses;      // All ones means brown-out off
    logic       comparator_bandgap_select; // Comparator wants the reference
    logic       converter_enabled;         // Converter enable bit
    logic       timer_async_select;        // Async timer runs on its own clock
  } rpc_periph_t;

  // Gate outputs, one bit per module, high stops the clock
  typedef struct packed {
    logic gate_two_wire;
    logic gate_timer_async8;
    logic gate_timer_first8;
    logic gate_serial_port_b;
    logic gate_timer_wide16;
    logic gate_sync_serial;
    logic gate_serial_port_a;
    logic gate_converter;
  } rpc_gates_t;

  localparam logic [2:0] BROWNOUT_OFF = 3'h7;

endpackage

/* verilog/rpc_top.sv */
// Reset sequencer, module power gates and bandgap control for the microcontroller
// What this block does
// - Bit 7 stops the two-wire clock
// - Bit 6 stops async timer only when synchronous
// - Bits 5 and 3 freeze the timers
// - Bits 4, 2, 1 stop serial clocks
// - Bit 0 stops converter; software disables it first
// - Internal reset loads gate register, core restarts
// - Port reset follows power, pin and test sources without clock
// - Delay counter stretches reset by fuse period
// - Internal reset combines five sources
// - Long external low pulse, counted on the clock, resets
// - External release starts delay counter
// - Watchdog resets only when enabled and expired
// - Test-port register one holds reset
// - Power-on asserts at once, release counts
// - Brown-out asserts after least duration, release counts
// - Brown-out ignores dips below least duration
// - Watchdog pulse one cycle, count from fall
// - Bandgap on for brown-out, comparator, converter
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps

module rpc_top
  import rpc_pkg::*;
#(
  parameter int STARTUP_LONG = rpc_pkg::STARTUP_LONG_CYC // Slow start-up count in cycles
) (
  input  wire  logic                  clk,
  input  wire  logic                  nrst,
  input  wire  rpc_pkg::rpc_sources_t sources,
  input  wire  rpc_pkg::rpc_periph_t  periph,
  input  wire  logic                  wb_cyc_i,
  input  wire  logic                  wb_stb_i,
  input  wire  logic                  wb_we_i,
  input  wire  logic [7:0]            wb_adr_i,
  input  wire  logic [31:0]           wb_dat_i,
  input  wire  logic [3:0]            wb_sel_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        int_reset_n,
  output logic                        port_reset_n,
  output rpc_pkg::rpc_gates_t         gates,
  output logic                        bandgap_on,
  output logic                        wdog_reset_pulse
);
  import rpc_pkg::*;

  localparam int CW = 20; // Counter width, holds the slow period
  localparam logic [CW-1:0] SHORT_CNT = CW'(STARTUP_SHORT_CYC);
  localparam logic [CW-1:0] LONG_CNT  = CW'(STARTUP_LONG);
  localparam logic [7:0]    BOD_CNT   = 8'(BROWNOUT_MIN_CYC);
  localparam logic [7:0]    EXT_CNT   = 8'(EXT_MIN_PULSE_CYC);

  // All state of the block but the port reset flop in one record
  typedef struct packed {
    rpc_state_t    st;        // Delay counter state
    logic [CW-1:0] cnt;       // Delay counter
    logic [7:0]    bod_cnt;   // Brown-out persistence count
    logic          bod_flag;  // Qualified brown-out
    logic [7:0]    ext_cnt;   // External low pulse width count
    logic          ext_flag;  // Qualified external reset
    logic          wdog_prev; // Previous expiry level for edge
    logic          wdog_pls;  // One-cycle watchdog reset pulse
    logic [7:0]    gates;     // Module power gate register
    logic [7:0]    config_r;  // Start-up fuse copy
    logic          ack;       // Bus acknowledge
    logic [31:0]   rdata;     // Bus read data
    logic          int_rst_n; // Registered internal reset
    logic          port_rst_n;// Registered port reset
    logic          bg;        // Bandgap enable
  } rpc_regs_t;

  rpc_regs_t r;
  rpc_regs_t next_r;

  logic any_source; // Any reset source active this cycle
  logic bod_raw;    // Brown-out comparator gated by enable
  logic bus_req;    // New Wishbone access
  logic [CW-1:0] period; // Selected delay period

  // Brown-out is only watched when the level fuses enable it
  assign bod_raw = sources.supply_low && (periph.brownout_level_fuses != BROWNOUT_OFF);

  // Five sources merged; power-on and test reset act at once
  assign any_source = sources.power_low | r.ext_flag | r.wdog_pls | r.bod_flag | sources.test_reset;

  // Period from start-up fuses; short only when the whole config register reads zero
  assign period = (r.config_r == CONFIG_RESET) ? SHORT_CNT : LONG_CNT;

  assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;

  // Next state of the whole block
  always_comb begin
    next_r = r;
    // External pin must stay low past the least pulse width
    if (!sources.ext_reset_n) begin
      if (r.ext_cnt != EXT_CNT) begin
        next_r.ext_cnt = r.ext_cnt + 8'h01;
      end
      next_r.ext_flag = (r.ext_cnt == EXT_CNT) || r.ext_flag;
    end else begin
      next_r.ext_cnt  = 8'h00;
      next_r.ext_flag = 1'b0; // Pin release starts the counter
    end
    // Brown-out must persist before it flags
    if (bod_raw) begin
      if (r.bod_cnt != BOD_CNT) begin
        next_r.bod_cnt = r.bod_cnt + 8'h01;
      end
      next_r.bod_flag = (r.bod_cnt == BOD_CNT) || r.bod_flag;
    end else begin
      next_r.bod_cnt  = 8'h00;
      next_r.bod_flag = 1'b0;
    end
    // Watchdog expiry edge while enabled gives one cycle pulse
    next_r.wdog_prev = sources.wdog_expired;
    next_r.wdog_pls  = sources.wdog_expired && !r.wdog_prev && sources.wdog_enabled;
    // Delay counter sequence
    case (r.st)
      RPC_ST_HOLD: begin
        next_r.cnt = '0;
        if (!any_source) begin
          next_r.st = RPC_ST_COUNT; // Starts after pulse falls
        end
      end
      RPC_ST_COUNT: begin
        if (any_source) begin
          next_r.st  = RPC_ST_HOLD; // Restart from zero
          next_r.cnt = '0;
        end else if (r.cnt >= period - CW'(1)) begin
          next_r.st = RPC_ST_RUN;
        end else begin
          next_r.cnt = r.cnt + CW'(1);
        end
      end
      RPC_ST_RUN: begin
        if (any_source) begin
          next_r.st = RPC_ST_HOLD;
        end
      end
      default: begin
        next_r.st = RPC_ST_HOLD;
      end
    endcase
    next_r.int_rst_n  = (next_r.st == RPC_ST_RUN);
    next_r.port_rst_n = !any_source;
    // Reference power
    next_r.bg = (periph.brownout_level_fuses != BROWNOUT_OFF) || periph.comparator_bandgap_select
                || periph.converter_enabled;
    // Wishbone slave, one wait state then ack
    next_r.ack = bus_req;
    if (bus_req) begin
      case (wb_adr_i)
        ADDR_MODULE_POWER_GATES: next_r.rdata = {24'h000000, r.gates};
        ADDR_RESET_CONFIG:       next_r.rdata = {24'h000000, r.config_r};
        ADDR_RESET_STATUS:       next_r.rdata = {28'h0000000, r.st != RPC_ST_RUN && r.st != RPC_ST_HOLD,
                                                 r.bg, r.port_rst_n, r.int_rst_n};
        default:                 next_r.rdata = 32'h00000000; // Unmapped reads zero
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == ADDR_MODULE_POWER_GATES) begin
          next_r.gates = wb_dat_i[7:0];
        end
        if (wb_adr_i == ADDR_RESET_CONFIG) begin
          next_r.config_r = wb_dat_i[7:0];
        end
      end
    end else begin
      next_r.rdata = 32'h00000000;
    end
    // Internal reset puts the gate register to its initial value
    if (r.st != RPC_ST_RUN) begin
      next_r.gates = GATES_RESET;
    end
  end

  // State register; constants only under reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Port reset: asynchronous path for clockless sources, the registered bus-visible path for the rest.
  // The combinational OR below is a trade-off: ports must drop without a clock, so it cannot be a flop.
  logic port_async_n;
  assign port_async_n = !(sources.power_low || !sources.ext_reset_n || sources.test_reset);

  // Port reset flop cleared asynchronously by any clockless source
  always_ff @(posedge clk or negedge port_async_n) begin
    if (!port_async_n) begin
      port_reset_n <= 1'b0;
    end else begin
      port_reset_n <= next_r.port_rst_n;
    end
  end

  // Output drive straight from flops
  assign wb_dat_o         = r.rdata;
  assign wb_ack_o         = r.ack;
  assign int_reset_n      = r.int_rst_n;
  assign bandgap_on       = r.bg;
  assign wdog_reset_pulse = r.wdog_pls;

  // Gates; async timer stops only in synchronous mode
  always_comb begin
    gates                    = rpc_gates_t'(r.gates);
    gates.gate_timer_async8  = r.gates[BIT_GATE_TIMER_ASYNC8] && !periph.timer_async_select;
  end

  // Checks on the sequencer, the gate register and the bus answer.
  // All run on the one clock and are quiet while nrst holds the block,
  // since every flop in r is forced to zero there and nothing is meaningful.

  // Watchdog pulse lasts exactly one cycle
  a_wdog_pulse_one: assert property (@(posedge clk) disable iff (!nrst)
    r.wdog_pls |=> !r.wdog_pls)
    else $error("watchdog pulse longer than one cycle");

  // Watchdog pulse only when enabled
  a_wdog_needs_en: assert property (@(posedge clk) disable iff (!nrst)
    r.wdog_pls |-> $past(sources.wdog_enabled))
    else $error("watchdog pulse while disabled");

  // Any source keeps internal reset low next cycle
  a_source_holds: assert property (@(posedge clk) disable iff (!nrst)
    any_source |=> !r.int_rst_n)
    else $error("reset released during source");

  // Restart from zero when source returns
  a_count_restart: assert property (@(posedge clk) disable iff (!nrst)
    (r.st == RPC_ST_COUNT && any_source) |=> (r.cnt == '0 && r.st == RPC_ST_HOLD))
    else $error("counter did not restart");

  // Release only after the full period
  a_release_late: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r.int_rst_n) |-> $past(r.cnt) >= period - CW'(1))
    else $error("release before period");

  // Converter enable powers the reference
  a_bandgap_map: assert property (@(posedge clk) disable iff (!nrst)
    periph.converter_enabled |=> r.bg)
    else $error("bandgap off with converter on");

  // Brown-out flag never before least duration
  a_bod_filter: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r.bod_flag) |-> r.bod_cnt == BOD_CNT)
    else $error("brown-out flagged early");

  // Power-on asserts port reset next edge at latest
  a_por_immediate: assert property (@(posedge clk) disable iff (!nrst)
    sources.power_low |-> ##1 !port_reset_n)
    else $error("port reset missed power-on");

  // Test-port register holds core in reset
  a_test_holds: assert property (@(posedge clk) disable iff (!nrst)
    sources.test_reset |=> r.st != RPC_ST_RUN)
    else $error("test reset not held");

  // Gate register returns to its initial value under internal reset
  a_gate_reset: assert property (@(posedge clk) disable iff (!nrst)
    r.st != RPC_ST_RUN |=> r.gates == GATES_RESET)
    else $error("gates not cleared by reset");

  // Async timer keeps its clock while on its own oscillator
  a_async_gate: assert property (@(posedge clk) disable iff (!nrst)
    periph.timer_async_select |-> !gates.gate_timer_async8)
    else $error("async timer gated in async mode");

  // A write in normal running lands in the gate register
  a_gate_write: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_MODULE_POWER_GATES && r.st == RPC_ST_RUN)
    |=> r.gates == $past(wb_dat_i[7:0]))
    else $error("gate write lost");

  // Gates hold their value without a write, so timers resume as left
  a_gate_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!bus_req && r.st == RPC_ST_RUN) |=> $stable(r.gates))
    else $error("gates changed without write");

  // Acknowledge is a single-cycle pulse
  a_ack_pulse: assert property (@(posedge clk) disable iff (!nrst)
    r.ack |=> !r.ack)
    else $error("ack longer than one cycle");

  // Every new request is answered on the next edge
  a_ack_answer: assert property (@(posedge clk) disable iff (!nrst)
    bus_req |=> r.ack)
    else $error("request not answered");

  // Enabled brown-out detection powers the reference
  a_bandgap_bod: assert property (@(posedge clk) disable iff (!nrst)
    (periph.brownout_level_fuses != BROWNOUT_OFF) |=> r.bg)
    else $error("bandgap off with brown-out on");

  // Comparator select powers the reference
  a_bandgap_comp: assert property (@(posedge clk) disable iff (!nrst)
    periph.comparator_bandgap_select |=> r.bg)
    else $error("bandgap off with comparator select");

  // No cause leaves the reference off
  a_bandgap_off: assert property (@(posedge clk) disable iff (!nrst)
    (periph.brownout_level_fuses == BROWNOUT_OFF && !periph.comparator_bandgap_select
     && !periph.converter_enabled) |=> !r.bg)
    else $error("bandgap on without cause");

  // Any qualified source resets the ports by the next edge
  a_port_source: assert property (@(posedge clk) disable iff (!nrst)
    any_source |=> !port_reset_n)
    else $error("port reset missed source");

  // Pin low clears ports at once, without an edge
  a_pin_port: assert property (@(posedge clk) disable iff (!nrst)
    !sources.ext_reset_n |-> !port_reset_n)
    else $error("port reset missed pin");

  // Test-port reset clears ports at once
  a_test_port: assert property (@(posedge clk) disable iff (!nrst)
    sources.test_reset |-> !port_reset_n)
    else $error("port reset missed test reset");

  // Watchdog pulse comes only from a rising expiry
  a_wdog_edge: assert property (@(posedge clk) disable iff (!nrst)
    r.wdog_pls |-> $past(sources.wdog_expired) && !$past(r.wdog_prev))
    else $error("watchdog pulse without expiry edge");

  // Watchdog pulse resets the core
  a_wdog_resets: assert property (@(posedge clk) disable iff (!nrst)
    r.wdog_pls |=> !r.int_rst_n)
    else $error("watchdog pulse ignored");

  // External flag only after the least pulse width
  a_ext_filter: assert property (@(posedge clk) disable iff (!nrst)
    $rose(r.ext_flag) |-> r.ext_cnt == EXT_CNT)
    else $error("external reset flagged early");

  // Pin release drops the flag so counting can start
  a_ext_release: assert property (@(posedge clk) disable iff (!nrst)
    sources.ext_reset_n |=> !r.ext_flag)
    else $error("external flag stuck after release");

  // Supply recovery drops the brown-out flag
  a_bod_release: assert property (@(posedge clk) disable iff (!nrst)
    !bod_raw |=> !r.bod_flag)
    else $error("brown-out flag stuck");

  // Quiet sources start the count from zero
  a_count_start: assert property (@(posedge clk) disable iff (!nrst)
    (r.st == RPC_ST_HOLD && !any_source) |=> (r.st == RPC_ST_COUNT && r.cnt == '0))
    else $error("count did not start");

  // The count advances one step per quiet cycle
  a_count_step: assert property (@(posedge clk) disable iff (!nrst)
    (r.st == RPC_ST_COUNT && !any_source && r.cnt < period - CW'(1)) |=> r.cnt == $past(r.cnt) + CW'(1))
    else $error("count skipped");

  // Internal reset is released only in the run state
  a_run_release: assert property (@(posedge clk) disable iff (!nrst)
    r.int_rst_n == (r.st == RPC_ST_RUN))
    else $error("internal reset out of step");

  // Power-on holds the core next edge
  a_power_core: assert property (@(posedge clk) disable iff (!nrst)
    sources.power_low |=> !r.int_rst_n)
    else $error("power-on did not hold core");

  // Qualified brown-out holds the core
  a_bod_core: assert property (@(posedge clk) disable iff (!nrst)
    r.bod_flag |=> !r.int_rst_n)
    else $error("brown-out did not hold core");

  // Qualified pin reset holds the core
  a_ext_core: assert property (@(posedge clk) disable iff (!nrst)
    r.ext_flag |=> !r.int_rst_n)
    else $error("pin reset did not hold core");

endmodule // rpc_top

/* test/rpc_far_model.sv */
// Peripheral-side model: the first 8-bit timer, which counts while its clock is not gated
`timescale 1ns/1ps

module rpc_far_model
  import rpc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                int_reset_n,
  input  wire rpc_pkg::rpc_gates_t gates,
  output logic [7:0]               first8_count
);
  // Counter freezes while gated and keeps its value, so a resume carries on from where it stopped
  always_ff @(posedge clk or negedge int_reset_n) begin
    if (!int_reset_n) begin
      first8_count <= 8'h00; // Reset loads the initial value
    end else if (!gates.gate_timer_first8) begin
      first8_count <= first8_count + 8'h01; // Runs only with its clock on
    end
  end
endmodule // rpc_far_model

/* test/tb.sv */
// Self-checking testbench for the reset sequencer, power gates and bandgap control
`timescale 1ns/1ps

module tb;
  import rpc_pkg::*;
  localparam int SL = 64;                                  // Shortened slow start-up count
  localparam int SP = STARTUP_SHORT_CYC;                   // Fast start-up count
  localparam rpc_sources_t IDLE = rpc_sources_t'(6'h10);   // Pin high, all else quiet
  logic         clk;
  logic         nrst;
  logic         cyc;
  logic         stb;
  logic         we;
  logic         ack;
  logic         bg;
  logic         wpulse;
  logic         irn;
  logic         prn;
  logic [7:0]   adr;
  logic [7:0]   cnt;
  logic [31:0]  wdat;
  logic [31:0]  rdat;
  logic [31:0]  rd;
  logic [3:0]   sel;
  rpc_sources_t src;
  rpc_periph_t  per;
  rpc_gates_t   gates;
  int           n_errors = 0;
  int           checked = 0;
  int           ticks = 0;

  rpc_top #(.STARTUP_LONG(SL)) uut (.clk(clk), .nrst(nrst), .sources(src), .periph(per), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .int_reset_n(irn), .port_reset_n(prn), .gates(gates), .bandgap_on(bg),
    .wdog_reset_pulse(wpulse));
  rpc_far_model far (.clk(clk), .int_reset_n(irn), .gates(gates), .first8_count(cnt));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard: the whole run needs under two thousand cycles
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 8000) begin
      n_errors++;
      complete_run;
    end
  end

  task automatic complete_run;
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // Classic single Wishbone cycle on byte lane 0; waits for ack without assuming a latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk("ack seen", 1, n < 20);
  endtask

  // Assert one reset source for n cycles; pin, power and test sources reach the ports at once
  task automatic hold(input int k, input int n);
    case (k)
      0: src.power_low <= 1'b1;
      1: src.ext_reset_n <= 1'b0;
      2: src.supply_low <= 1'b1;
      default: src.test_reset <= 1'b1;
    endcase
    #1;
    if (k != 2) chk("port_reset_n", 0, prn);
    repeat (n) @(posedge clk);
    src <= IDLE;
  endtask

  // Count cycles until the internal reset releases and judge the window
  task automatic wait_up(input int lo, input int hi);
    int n;
    n = 0;
    while (irn !== 1'b1 && n <= hi) begin
      @(posedge clk);
      n++;
    end
    chk("release window", 1, n >= lo && n <= hi);
  endtask

  // Registers, gate outputs and a timer frozen by its gate
  task automatic t_regs;
    logic [7:0] c0;
    wb(1'b0, ADDR_RESET_STATUS, 8'h00);
    chk("status", 32'h7, rd);
    wb(1'b0, ADDR_MODULE_POWER_GATES, 8'h00);
    chk("gates reset value", 0, rd);
    wb(1'b0, 8'h70, 8'h00);
    chk("unmapped read", 0, rd);
    wb(1'b1, ADDR_MODULE_POWER_GATES, 8'hff); // Converter already disabled
    chk("gates all", 8'hff, gates);
    c0 = cnt;
    repeat (10) @(posedge clk);
    chk("timer frozen", c0, cnt);
    per.timer_async_select <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk("gates async timer", 8'hbf, gates);
    per.timer_async_select <= 1'b0;
    wb(1'b0, ADDR_MODULE_POWER_GATES, 8'h00);
    chk("gates readback", 32'hff, rd);
    wb(1'b1, ADDR_MODULE_POWER_GATES, 8'h00);
    c0 = cnt;
    repeat (10) @(posedge clk);
    chk("timer resumed", c0 + 8'd10, cnt);
  endtask

  // Bandgap demand from brown-out fuses, comparator select and converter enable
  task automatic t_bg;
    logic [5:0] pv[4] = '{6'h38, 6'h20, 6'h3c, 6'h3a};
    logic       ev[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      per <= rpc_periph_t'(pv[i]);
      repeat (3) @(posedge clk); // Reference start-up allowance
      chk("bandgap_on", ev[i], bg);
    end
    per <= rpc_periph_t'(6'h20);
  endtask

  // Short pin and supply dips are ignored; long ones and any power or test reset hold the core
  task automatic t_src;
    int ks[6] = '{1, 1, 2, 2, 0, 3};
    int ns[6] = '{40, 130, 40, 130, 5, 20};
    for (int i = 0; i < 6; i++) begin
      hold(ks[i], ns[i]);
      if (ns[i] == 40) begin
        repeat (4) @(posedge clk);
        chk("short dip ignored", 1, irn);
      end else begin
        chk("int_reset_n held", 0, irn);
        wait_up(SP, SP + 8);
      end
    end
  endtask

  // Watchdog expiry resets only when enabled, with a one-cycle pulse
  task automatic t_wdog(input int p);
    int n;
    src.wdog_expired <= 1'b1;
    repeat (4) @(posedge clk);
    chk("watchdog disabled", 1, irn);
    src <= IDLE;
    @(posedge clk);
    src.wdog_enabled <= 1'b1;
    src.wdog_expired <= 1'b1;
    n = 0;
    repeat (4) begin
      @(posedge clk);
      n += int'(wpulse === 1'b1);
    end
    chk("watchdog pulse width", 1, n);
    src <= IDLE;
    wait_up(p - 6, p + 6);
  endtask

  // A source reappearing during the count restarts it; the gate register comes back at its initial value
  task automatic t_restart;
    wb(1'b1, ADDR_MODULE_POWER_GATES, 8'h0f);
    hold(3, 5);
    repeat (30) @(posedge clk);
    chk("count restart held", 0, irn);
    hold(3, 5);
    wait_up(SL, SL + 8);
    wb(1'b0, ADDR_MODULE_POWER_GATES, 8'h00);
    chk("gates after reset", 0, rd);
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    src = IDLE;
    per = rpc_periph_t'(6'h20);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wait_up(SP, SP + 8);
    t_regs;
    t_bg;
    t_src;
    t_wdog(SP);
    wb(1'b1, ADDR_RESET_CONFIG, 8'h10);
    t_wdog(SL);
    t_restart;
    complete_run;
  end
endmodule // tb
